//--- hdl/bprf_pkg.sv
// Shared constants and types for the boot program request framer
package bprf_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int          AXI_AW     = 8;
	localparam logic [7:0]  A_CTRL     = 8'h00;
	localparam logic [7:0]  A_STAT     = 8'h04;
	localparam logic [7:0]  A_LSA_LO   = 8'h08;
	localparam logic [7:0]  A_LSA_HI   = 8'h0c;
	localparam logic [7:0]  A_PHY_LO   = 8'h10;
	localparam logic [7:0]  A_PHY_HI   = 8'h14;
	localparam logic [7:0]  A_XLEN     = 8'h18;
	localparam logic [7:0]  A_SWID     = 8'h1c;
	localparam logic [7:0]  A_XDAT     = 8'h20;
	localparam int          C_BOOT     = 0;
	localparam int          C_PROC     = 1;
	localparam int          C_FUNC15   = 2;
	localparam int          C_RELEASE  = 3;
	localparam logic [47:0] PHY_RST    = 48'h0;
	localparam logic [47:0] LSA_RST    = 48'h0;
	localparam logic [1:0]  RESP_OK    = 2'h0;
	localparam logic [1:0]  RESP_ERR   = 2'h2;

	// ----------------------------------------
	// Frame field values
	// ----------------------------------------
	localparam logic [7:0]  TYPE_LO    = 8'h60;
	localparam logic [7:0]  TYPE_HI    = 8'h01;
	localparam logic [7:0]  FCODE      = 8'h08;
	localparam logic [7:0]  FMT_VER    = 8'h01;
	localparam logic [7:0]  PROG_TYPE  = 8'h00;
	localparam logic [7:0]  PROC_SYS   = 8'h00;
	localparam logic [7:0]  PROC_COMM  = 8'h01;
	localparam logic [7:0]  CTL_DEFLT  = 8'h00;
	localparam logic [7:0]  CTL_PEER   = 8'h01;
	localparam logic [7:0]  VER_T      = 8'h01;
	localparam logic [7:0]  VER_L      = 8'h03;
	localparam logic [7:0]  VER_V      = 8'h03;
	localparam logic [7:0]  FUNC_T     = 8'h02;
	localparam logic [7:0]  FUNC_L     = 8'h02;
	localparam logic [7:0]  FUNC_V1    = 8'h05;
	localparam logic [7:0]  FUNC_V1X   = 8'h15;
	localparam logic [7:0]  HWA_T      = 8'h07;
	localparam logic [7:0]  HWA_L      = 8'h06;
	localparam logic [7:0]  DEV_T      = 8'h64;
	localparam logic [7:0]  DEV_L      = 8'h01;
	localparam logic [7:0]  MIN_CNT    = 8'h1d;
	localparam logic [7:0]  MAX_CNT    = 8'haf;

	// ----------------------------------------
	// Field positions and lengths in bytes
	// ----------------------------------------
	localparam logic [7:0]  P_SRC      = 8'd6;
	localparam logic [7:0]  P_TYPE     = 8'd12;
	localparam logic [7:0]  P_CNT      = 8'd14;
	localparam logic [7:0]  P_CODE     = 8'd16;
	localparam logic [7:0]  P_DTYPE    = 8'd17;
	localparam logic [7:0]  P_FMT      = 8'd18;
	localparam logic [7:0]  P_PTYPE    = 8'd19;
	localparam logic [7:0]  P_PROC     = 8'd20;
	localparam logic [7:0]  P_VER      = 8'd21;
	localparam logic [7:0]  P_FUNC     = 8'd27;
	localparam logic [7:0]  P_HWA      = 8'd32;
	localparam logic [7:0]  P_DEV      = 8'd41;
	localparam logic [7:0]  P_SWID     = 8'd45;
	localparam logic [7:0]  P_XTRA     = 8'd46;
	localparam logic [7:0]  FIXED_CNT  = 8'd30;
	localparam logic [7:0]  MIN_FRAME  = 8'd60;
	localparam logic [1:0]  FCS_LAST   = 2'd3;

	typedef struct packed {
		logic [47:0] src;
		logic [7:0]  control;
		logic [7:0]  sw_id;
		logic [7:0]  processor;
	} bprf_boot_t;

	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_ASM   = 5'b00010,
		S_START = 5'b00100,
		S_SEND  = 5'b01000,
		S_FCS   = 5'b10000
	} bprf_state_t;

endpackage : bprf_pkg

//--- hdl/bprf_sync.sv
// Two-stage synchroniser for a level arriving from outside the clock domain
module bprf_sync #(
	parameter int STAGES = 2
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Level in and out
	input  wire logic din,
	output logic      dout
);
	logic [STAGES-1:0] sr_q;

	if (STAGES < 2) begin : g_chk
		$error("bprf_sync needs at least two stages");
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sr_q <= '0;
		end else begin
			sr_q <= {sr_q[STAGES-2:0], din};
		end
	end

	assign dout = sr_q[STAGES-1];

endmodule : bprf_sync

//--- hdl/bprf_crc32.sv
// Byte-wide frame check sequence generator, reflected form
module bprf_crc32 (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Control and data
	input  wire logic        clear,
	input  wire logic        en,
	input  wire logic [7:0]  data,
	output logic      [31:0] crc_q
);
	logic [31:0] crc_d;

	always_comb begin
		crc_d = crc_q ^ {24'h0, data};
		for (int i = 0; i < 8; i++) begin
			crc_d = crc_d[0] ? ((crc_d >> 1) ^ 32'hedb88320) : (crc_d >> 1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			crc_q <= 32'hffffffff;
		end else if (en) begin
			crc_q <= crc_d;
		end
	end

endmodule : bprf_crc32

//--- hdl/bprf_top.sv
// Boot program request framer with its register slave
//
// Overview of operation
// - System boot asserts halt line, blocks bus init
// - Copy boot software id into request
// - Control 1: destination is boot sender
// - Control 0: destination is stored server address
// - No server address stored: use multicast
// - Start loader only after frame assembled
// - Source field carries own station address
// - Type field sent as 60 then 01
// - Count low byte first, 1D to AF
// - Code 08, fixed version and program type
// - Device type byte follows code
// - Processor 00 system, 01 controller
// - Version parameter 01-00, 03, 03 00 00
// - Function parameter 02-00, 02, 05/15, 00
// - Hardware address parameter 07-00, 06, address
// - Device parameter 64-00, length, device code
// - Append host parameters, zero pad frame
// - Append four-byte frame check sequence
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
module bprf_top
	import bprf_pkg::*;
#(
	parameter logic [7:0]  DEV_TYPE_CODE = 8'h2a,            // Arbitrary value
	parameter logic [7:0]  DEV_CODE      = 8'h2a,            // Arbitrary value
	parameter logic [47:0] MCAST_ADDR    = 48'h030000a5a500, // Arbitrary value
	parameter int          XTRA_MAX      = 145
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [AXI_AW-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [AXI_AW-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Validated boot message
	input  wire bprf_boot_t        boot_msg,
	input  wire logic              boot_valid,
	// Host pins
	input  wire logic              host_init,
	output logic                   powerfail_halt_line,
	output logic                   init_to_core,
	// Transmit byte stream
	output logic [7:0]             tx_data,
	output logic                   tx_valid,
	output logic                   tx_last,
	input  wire logic              tx_ready,
	output logic                   loader_start
);
	localparam int FRAME_MAX = 16 + 30 + XTRA_MAX;

	if (XTRA_MAX < 1 || XTRA_MAX > int'(MAX_CNT - FIXED_CNT)) begin : g_chk
		$error("XTRA_MAX outside what the count field can carry");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic reg_ok(input logic [AXI_AW-1:0] a);
		case (a)
			A_CTRL, A_STAT, A_LSA_LO, A_LSA_HI, A_PHY_LO, A_PHY_HI,
			A_XLEN, A_SWID, A_XDAT: reg_ok = 1'b1;
			default: reg_ok = 1'b0;
		endcase
	endfunction : reg_ok

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		merge = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				merge[8*b +: 8] = n[8*b +: 8];
			end
		end
	endfunction : merge

	// First octet of an address sits in bits 47:40
	function automatic logic [7:0] octet(input logic [47:0] a, input logic [7:0] k);
		logic [47:0] s;
		s = a << (8 * k[2:0]);
		octet = s[47:40];
	endfunction : octet

	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]        bresp_q, rresp_q;
	logic [31:0]       rdata_q, wd_q;
	logic [3:0]        ws_q;
	logic [AXI_AW-1:0] wa_q;
	logic              wr_go;
	logic [47:0]       lsa_q, phy_q;
	logic              lsa_valid_q, proc_sel_q, func15_q, cmd_boot_q;
	logic [7:0]        xlen_q, swid_reg_q;
	logic [7:0]        xmem [XTRA_MAX];
	bprf_state_t       state_q;
	logic              halt_q;
	logic [7:0]        len_q;

	assign wr_go = !awready_q && !wready_q && !bvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OK;
		end else begin
			if (awvalid && awready_q) begin
				awready_q <= 1'b0;
				wa_q      <= awaddr;
			end
			if (wvalid && wready_q) begin
				wready_q <= 1'b0;
				wd_q     <= wdata;
				ws_q     <= wstrb;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= reg_ok(wa_q) ? RESP_OK : RESP_ERR;
			end else if (bvalid_q && bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lsa_q       <= LSA_RST;
			phy_q       <= PHY_RST;
			lsa_valid_q <= 1'b0;
			proc_sel_q  <= 1'b0;
			func15_q    <= 1'b0;
			cmd_boot_q  <= 1'b0;
			xlen_q      <= 8'h00;
			swid_reg_q  <= 8'h00;
		end else begin
			cmd_boot_q <= wr_go && wa_q == A_CTRL && ws_q[0] && wd_q[C_BOOT];
			if (wr_go) begin
				case (wa_q)
					A_CTRL: if (ws_q[0]) begin
						proc_sel_q <= wd_q[C_PROC];
						func15_q   <= wd_q[C_FUNC15];
					end
					A_LSA_LO: lsa_q[31:0] <= merge(lsa_q[31:0], wd_q, ws_q);
					A_LSA_HI: begin
						lsa_q[47:32] <= 16'(merge({16'h0, lsa_q[47:32]}, wd_q, ws_q));
						lsa_valid_q  <= 1'b1;
					end
					A_PHY_LO: phy_q[31:0] <= merge(phy_q[31:0], wd_q, ws_q);
					A_PHY_HI: phy_q[47:32] <= 16'(merge({16'h0, phy_q[47:32]}, wd_q, ws_q));
					A_XLEN: if (ws_q[0] && int'(wd_q[7:0]) <= XTRA_MAX) begin
						xlen_q <= wd_q[7:0];
					end
					A_SWID: if (ws_q[0]) begin
						swid_reg_q <= wd_q[7:0];
					end
					default: ;
				endcase
			end
		end
	end

	// Parameter bytes: index in bits 15:8, value in bits 7:0
	always_ff @(posedge aclk) begin
		if (wr_go && wa_q == A_XDAT && ws_q[0] && int'(wd_q[15:8]) < XTRA_MAX) begin
			xmem[wd_q[15:8]] <= wd_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= RESP_OK;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= reg_ok(araddr) ? RESP_OK : RESP_ERR;
			case (araddr)
				A_CTRL:   rdata_q <= {28'h0, 1'b0, func15_q, proc_sel_q, 1'b0};
				A_STAT:   rdata_q <= {8'h0, len_q, 6'h0, lsa_valid_q, halt_q, 3'h0, state_q};
				A_LSA_LO: rdata_q <= lsa_q[31:0];
				A_LSA_HI: rdata_q <= {16'h0, lsa_q[47:32]};
				A_PHY_LO: rdata_q <= phy_q[31:0];
				A_PHY_HI: rdata_q <= {16'h0, phy_q[47:32]};
				A_XLEN:   rdata_q <= {24'h0, xlen_q};
				A_SWID:   rdata_q <= {24'h0, swid_reg_q};
				default:  rdata_q <= 32'h0;
			endcase
		end else if (rvalid_q && rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Host halt and bus init blocking
	// ----------------------------------------
	logic init_s, init_q, boot_take;

	bprf_sync #(.STAGES(2)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (host_init),
		.dout    (init_s)
	);

	assign boot_take = boot_valid && state_q == S_IDLE;

	// Set wins over a release written in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_q <= 1'b0;
		end else if (boot_take && boot_msg.processor == PROC_SYS) begin
			halt_q <= 1'b1;
		end else if (wr_go && wa_q == A_CTRL && ws_q[0] && wd_q[C_RELEASE]) begin
			halt_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_q <= 1'b0;
		end else begin
			init_q <= init_s && !halt_q;
		end
	end

	// ----------------------------------------
	// Frame assembly and transmit
	// ----------------------------------------
	logic [7:0]  idx_q, swid_q, proc_q, asm_byte, cnt;
	logic [47:0] dest_q;
	logic [1:0]  fcs_q;
	logic [7:0]  fmem [FRAME_MAX];
	logic [31:0] crc_val;
	logic        txv_q, txl_q, start_q, load;
	logic [7:0]  txd_q;

	// Sole extra-length source keeps the count inside 1D..AF
	assign cnt  = FIXED_CNT + xlen_q;
	assign load = (state_q == S_SEND || state_q == S_FCS) && (!txv_q || tx_ready);

	always_comb begin
		asm_byte = 8'h00;
		if (idx_q < P_SRC) begin
			asm_byte = octet(dest_q, idx_q);
		end else if (idx_q < P_TYPE) begin
			asm_byte = octet(phy_q, idx_q - P_SRC);
		end else if (idx_q >= 8'(P_HWA + 3) && idx_q < P_DEV) begin
			asm_byte = octet(phy_q, idx_q - 8'(P_HWA + 3));
		end else if (idx_q >= P_XTRA && idx_q < P_XTRA + xlen_q) begin
			asm_byte = xmem[idx_q - P_XTRA];
		end else begin
			case (idx_q)
				P_TYPE:          asm_byte = TYPE_LO;
				8'(P_TYPE + 1):  asm_byte = TYPE_HI;
				P_CNT:           asm_byte = cnt;
				P_CODE:          asm_byte = FCODE;
				P_DTYPE:         asm_byte = DEV_TYPE_CODE;
				P_FMT:           asm_byte = FMT_VER;
				P_PTYPE:         asm_byte = PROG_TYPE;
				P_PROC:          asm_byte = proc_q;
				P_VER:           asm_byte = VER_T;
				8'(P_VER + 2):   asm_byte = VER_L;
				8'(P_VER + 3):   asm_byte = VER_V;
				P_FUNC:          asm_byte = FUNC_T;
				8'(P_FUNC + 2):  asm_byte = FUNC_L;
				8'(P_FUNC + 3):  asm_byte = func15_q ? FUNC_V1X : FUNC_V1;
				P_HWA:           asm_byte = HWA_T;
				8'(P_HWA + 2):   asm_byte = HWA_L;
				P_DEV:           asm_byte = DEV_T;
				8'(P_DEV + 2):   asm_byte = DEV_L;
				8'(P_DEV + 3):   asm_byte = DEV_CODE;
				P_SWID:          asm_byte = swid_q;
				default:         asm_byte = 8'h00;
			endcase
		end
	end

	bprf_crc32 u_crc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (state_q == S_IDLE),
		.en      (state_q == S_ASM),
		.data    (asm_byte),
		.crc_q   (crc_val)
	);

	// Boot requests that arrive while a frame is in progress are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_IDLE;
			idx_q   <= 8'h00;
			len_q   <= 8'h00;
			fcs_q   <= 2'd0;
			dest_q  <= 48'h0;
			swid_q  <= 8'h00;
			proc_q  <= PROC_SYS;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			case (state_q)
				S_IDLE: if (boot_valid || cmd_boot_q) begin
					state_q <= S_ASM;
					idx_q   <= 8'h00;
					len_q   <= (P_XTRA + xlen_q > MIN_FRAME) ? P_XTRA + xlen_q : MIN_FRAME;
					if (boot_valid) begin
						swid_q <= boot_msg.sw_id;
						proc_q <= boot_msg.processor;
						if (boot_msg.control == CTL_PEER) begin
							dest_q <= boot_msg.src;
						end else begin
							dest_q <= lsa_valid_q ? lsa_q : MCAST_ADDR;
						end
					end else begin
						swid_q <= swid_reg_q;
						proc_q <= proc_sel_q ? PROC_COMM : PROC_SYS;
						dest_q <= lsa_valid_q ? lsa_q : MCAST_ADDR;
					end
				end
				S_ASM: begin
					fmem[idx_q] <= asm_byte;
					idx_q       <= idx_q + 8'd1;
					if (idx_q == len_q - 8'd1) begin
						state_q <= S_START;
					end
				end
				S_START: begin
					start_q <= 1'b1;
					idx_q   <= 8'h00;
					state_q <= S_SEND;
				end
				S_SEND: if (load) begin
					idx_q <= idx_q + 8'd1;
					if (idx_q == len_q - 8'd1) begin
						state_q <= S_FCS;
						fcs_q   <= 2'd0;
					end
				end
				S_FCS: if (load) begin
					fcs_q <= fcs_q + 2'd1;
					if (fcs_q == FCS_LAST) begin
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txv_q <= 1'b0;
			txl_q <= 1'b0;
			txd_q <= 8'h00;
		end else if (load) begin
			txv_q <= 1'b1;
			txl_q <= state_q == S_FCS && fcs_q == FCS_LAST;
			txd_q <= state_q == S_SEND ? fmem[idx_q] : ~crc_val[8*fcs_q +: 8];
		end else if (tx_ready) begin
			txv_q <= 1'b0;
			txl_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign awready = awready_q;
	assign wready  = wready_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = arready_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
	assign powerfail_halt_line = halt_q;
	assign init_to_core = init_q;
	assign tx_data  = txd_q;
	assign tx_valid = txv_q;
	assign tx_last  = txl_q;
	assign loader_start = start_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	halt_on_boot_a: assert property (boot_take && boot_msg.processor == PROC_SYS |=> halt_q)
		else $error("halt line not raised on system boot");
	init_block_a: assert property (halt_q |=> !init_q)
		else $error("bus init passed while halted");
	swid_copy_a: assert property (boot_take |=> swid_q == $past(boot_msg.sw_id))
		else $error("software id not copied");
	dest_peer_a: assert property (boot_take && boot_msg.control == CTL_PEER
			|=> dest_q == $past(boot_msg.src))
		else $error("destination not boot sender");
	dest_default_a: assert property (boot_take && boot_msg.control == CTL_DEFLT
			|=> dest_q == ($past(lsa_valid_q) ? $past(lsa_q) : MCAST_ADDR))
		else $error("destination not server or multicast");
	start_order_a: assert property (state_q == S_ASM && idx_q == len_q - 8'd1
			|=> ##1 start_q ##1 !start_q)
		else $error("loader start not after assembly");
	type_field_a: assert property (state_q == S_ASM && idx_q == P_TYPE
			|-> asm_byte == TYPE_LO ##1 asm_byte == TYPE_HI)
		else $error("type field wrong");
	count_range_a: assert property (state_q == S_ASM && idx_q == P_CNT
			|-> asm_byte >= MIN_CNT && asm_byte <= MAX_CNT)
		else $error("count out of range");
	code_field_a: assert property (state_q == S_ASM && idx_q == P_CODE
			|-> asm_byte == FCODE ##1 asm_byte == DEV_TYPE_CODE)
		else $error("code or device type wrong");
	pad_zero_a: assert property (state_q == S_ASM && idx_q >= P_XTRA + xlen_q
			|-> asm_byte == 8'h00)
		else $error("pad byte not zero");

	sys_boot_c: cover property (boot_take && boot_msg.processor == PROC_SYS);
	comm_boot_c: cover property (boot_take && boot_msg.processor == PROC_COMM);
	local_boot_c: cover property (cmd_boot_q && state_q == S_IDLE);
	frame_end_c: cover property (txv_q && txl_q && tx_ready);

endmodule : bprf_top

//--- verification/bprf_load_server.sv
// Load server station model that sinks the request frame, stalling on demand
module bprf_load_server
	import bprf_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Frame stream
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       tx_last,
	output logic            tx_ready,
	// Capture
	input  wire logic       slow,
	output logic [7:0]      rx_q [0:255],
	output int              len_q,
	output int              nfr_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic stall_q;
	int   cnt_q;
	// A slow server takes one byte in two, so the framer must hold each byte
	assign tx_ready = ~stall_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stall_q <= 1'b0;
			cnt_q   <= 0;
			len_q   <= 0;
			nfr_q   <= 0;
		end else begin
			stall_q <= slow & ~stall_q;
			if (tx_valid && tx_ready) begin
				rx_q[cnt_q[7:0]] <= tx_data;
				cnt_q            <= tx_last ? 0 : cnt_q + 1;
				if (tx_last) begin
					len_q <= cnt_q + 1;
					nfr_q <= nfr_q + 1;
				end
			end
		end
	end
endmodule : bprf_load_server

//--- verification/tb_boot_program_request_framer.sv
// Self-checking bench for the boot program request framer
module tb_boot_program_request_framer
	import bprf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [7:0]  DTC  = 8'h3c;             // Arbitrary value
	localparam logic [7:0]  DCD  = 8'h5e;             // Arbitrary value
	localparam logic [47:0] MCA  = 48'h0b0000123400;  // Arbitrary value
	localparam logic [47:0] PHY  = 48'h02a1b2c3d4e5;
	localparam logic [47:0] LSA  = 48'h021122334455;
	localparam logic [47:0] SRC  = 48'h026677889900;
	logic              aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0, boot_valid = 1'b0, host_init = 1'b0, slow = 1'b0;
	logic [AXI_AW-1:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]       wdata = 32'h0;
	bprf_boot_t        boot_msg = '0;
	logic              awready, wready, bvalid, arready, rvalid, halt, init_to_core;
	logic              tx_valid, tx_last, tx_ready, loader_start;
	logic [1:0]        bresp, rresp, r;
	logic [31:0]       rdata, d;
	logic [7:0]        tx_data;
	logic [7:0]        rx [0:255];
	logic [7:0]        xp [0:63];
	int                len, nfr, n_mismatch = 0, checks_done = 0;

	initial begin
		forever #2.5 aclk = ~aclk;
	end

	bprf_top #(.DEV_TYPE_CODE(DTC), .DEV_CODE(DCD), .MCAST_ADDR(MCA), .XTRA_MAX(145)) i_bprf_top (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .boot_msg(boot_msg), .boot_valid(boot_valid),
		.host_init(host_init), .powerfail_halt_line(halt), .init_to_core(init_to_core),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
		.loader_start(loader_start));

	bprf_load_server i_bprf_load_server (.aclk(aclk), .aresetn(aresetn), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow), .rx_q(rx),
		.len_q(len), .nfr_q(nfr));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask : check

	task automatic give_verdict();
		if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] v);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		// One idle edge so a following call never re-raises bready in the same step
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [AXI_AW-1:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd

	task automatic boot(input logic [7:0] c, input logic [7:0] p, input logic [7:0] s);
		boot_msg   <= {SRC, c, s, p};
		boot_valid <= 1'b1;
		@(posedge aclk);
		boot_valid <= 1'b0;
	endtask : boot

	// Builds the expected frame, waits for it and compares every byte
	task automatic run(input logic [47:0] a, input logic [7:0] p, input logic [7:0] f, input logic [7:0] s,
			input logic [7:0] x);
		logic [8*46-1:0] h;
		logic [31:0]     c;
		int              n0;
		h = {a, PHY, 16'h6001, 8'h1e + x, 8'h00, 8'h08, DTC, 8'h01, 8'h00, p, 48'h010003030000,
			24'h020002, f, 8'h00, 24'h070006, PHY, 24'h640001, DCD, s};
		for (int i = 0; i < 60; i++) xp[i] = (i < 46) ? h[8*(45-i) +: 8] : 8'h00;
		for (int i = 0; i < x; i++) xp[46+i] = 8'ha0 + i[7:0];
		c = 32'hffffffff;
		for (int i = 0; i < 60; i++) begin
			c = c ^ {24'h0, xp[i]};
			for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
		end
		for (int k = 0; k < 4; k++) xp[60+k] = ~c[8*k +: 8];
		do @(posedge aclk); while (!loader_start);
		check("tx before start", {31'h0, tx_valid}, 0);
		n0 = nfr;
		do @(posedge aclk); while (nfr == n0);
		check("frame length", len, 64);
		for (int i = 0; i < 6; i++) check("dest", rx[i], xp[i]);
		check("processor", rx[20], p);
		check("software id", rx[45], s);
		for (int i = 6; i < 32; i++) check("head", rx[i], xp[i]);
		for (int i = 32; i < 60; i++) check("tail", rx[i], xp[i]);
		for (int i = 60; i < 64; i++) check("fcs", rx[i], xp[i]);
	endtask : run

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_sys_peer();
		axi_rd(A_STAT);
		check("stat idle", d, 32'h1);
		axi_rd(8'h40);
		check("unmapped read", {r, d[29:0]}, 32'h80000000);
		axi_wr(A_PHY_LO, PHY[31:0]);
		axi_wr(A_PHY_HI, {16'h0, PHY[47:32]});
		boot(8'h01, 8'h00, 8'hff);
		run(SRC, 8'h00, 8'h05, 8'hff, 0);
		check("halt", {31'h0, halt}, 1);
		host_init <= 1'b1;
		repeat (6) @(posedge aclk);
		check("init masked", {31'h0, init_to_core}, 0);
		axi_wr(A_CTRL, 32'h8);
		repeat (6) @(posedge aclk);
		check("init passes", {31'h0, init_to_core}, 1);
		check("halt released", {31'h0, halt}, 0);
		host_init <= 1'b0;
	endtask : t_sys_peer

	task automatic t_mcast_busy();
		slow <= 1'b1;
		boot(8'h00, 8'h01, 8'hfe);
		@(posedge aclk);
		boot(8'h01, 8'h00, 8'h11);
		run(MCA, 8'h01, 8'h05, 8'hfe, 0);
		// Long enough for a wrongly queued request to have reached the stream
		repeat (70) @(posedge aclk);
		check("no second frame", {31'h0, tx_valid}, 0);
		check("no halt", {31'h0, halt}, 0);
		slow <= 1'b0;
	endtask : t_mcast_busy

	task automatic t_local_server();
		axi_wr(A_LSA_LO, LSA[31:0]);
		axi_wr(A_LSA_HI, {16'h0, LSA[47:32]});
		axi_wr(A_SWID, 32'h42);
		axi_wr(A_XLEN, 32'h2);
		axi_wr(A_XDAT, 32'h00a0);
		axi_wr(A_XDAT, 32'h01a1);
		axi_wr(8'h44, 32'h0);
		check("unmapped write", {30'h0, r}, 2);
		axi_wr(A_CTRL, 32'h7);
		run(LSA, 8'h01, 8'h15, 8'h42, 2);
		check("local no halt", {31'h0, halt}, 0);
		boot(8'h00, 8'h01, 8'h33);
		run(LSA, 8'h01, 8'h15, 8'h33, 2);
	endtask : t_local_server

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_sys_peer();
		t_mcast_busy();
		t_local_server();
		give_verdict();
	end

	initial begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		give_verdict();
	end
endmodule : tb_boot_program_request_framer
